/* File: rtl/wwd_top.sv */
// window watchdog: control/status/rearm registers and timeout logic
// assumes single-cycle register strobes on clk and a power controller
// giving normal_mode on clk; the oscillator pin is asynchronous
`include "wwd_regs.svh"

module wwd_top
#(
  parameter int LP_TICKS_PER_MS = 16, // oscillator edges per ms
  parameter int CNT_W           = 20  // tick counter width
)
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // low-power oscillator pin
  input  wire logic          low_power_osc_clock,
  // power mode, high in Normal mode
  input  wire logic          normal_mode,
  // register access
  input  wire wwd_pkg::wwd_req_t req,
  output wwd_pkg::wwd_rsp_t  rsp,
  // reset request to the reset logic
  output logic               wd_reset_req
);

  // state and counters
  wwd_pkg::wwd_state_t state_r;   // current state
  wwd_pkg::wwd_state_t state_nxt; // next state
  logic [CNT_W-1:0]    cnt_r;     // tick counter
  logic [CNT_W-1:0]    cnt_nxt;   // next tick count
  logic [CNT_W-1:0]    limit;     // active timeout in ticks

  // register contents
  logic [2:0] timeout_select_r;    // timeout selector
  logic [2:0] timeout_select_nxt;  // next selector
  logic       test_bit_r;          // test bit, no function
  logic       test_bit_nxt;        // next test bit
  logic       locked_r;            // 000 writes no longer taken
  logic       locked_nxt;          // next lock
  logic       key_b_next_r;        // next key expected is 0x55
  logic       key_b_next_nxt;      // next expected key
  logic [7:0] rearm_val_r;         // last rearm byte taken in Normal mode, not when disabled
  logic       normal_d_r;          // delayed normal_mode

  // strobes and decode
  logic       tick;        // oscillator tick
  logic       hit;         // address in either window
  logic [7:0] ofs;         // offset within the window
  logic       ctl_wr;      // control write
  logic       rr_wr;       // rearm write
  logic [7:0] key;         // rearm byte of the access
  logic       wake;        // return to Normal mode
  logic       restart;     // return to power-on state
  logic       fire;        // watchdog reset this cycle
  logic       win_open;    // window open flag
  logic       dis_flag;    // disabled flag
  logic [7:0] status;      // status byte

  // tick generator on the oscillator pin
  wwd_lp_tick u_tick
  (
    .clk       (clk),
    .resetn    (resetn),
    .lp_osc_in (low_power_osc_clock),
    .tick      (tick)
  );

  // timeout selector to oscillator ticks
  function automatic logic [CNT_W-1:0] to_ticks(input logic [2:0] sel);
    int ms;
    ms = 0;
    case (sel)
      3'h1:    ms = `WWD_TO1_MS;
      3'h2:    ms = `WWD_TO2_MS;
      3'h3:    ms = `WWD_TO3_MS;
      3'h4:    ms = `WWD_TO4_MS;
      3'h5:    ms = `WWD_TO5_MS;
      3'h6:    ms = `WWD_TO6_MS;
      3'h7:    ms = `WWD_TO7_MS;
      default: ms = 0;
    endcase
    return CNT_W'(ms * LP_TICKS_PER_MS);
  endfunction : to_ticks

  // byte of an access that lands on the addressed register
  function automatic logic [7:0] lane(input logic sz16,
                                      input logic [15:0] d);
    // big-endian: 16-bit access puts the even byte high
    return sz16 ? d[15:8] : d[7:0];
  endfunction : lane

  // window decode, two bases
  always_comb
  begin
    hit = ((req.addr & `WWD_BASE_MASK) == `WWD_BASE_BLK) ||
          ((req.addr & `WWD_BASE_MASK) == `WWD_BASE_NBLK);
    ofs = req.addr[7:0];
  end

  // write strobes
  assign ctl_wr = req.wr && hit && ofs == `WWD_OFS_CTL && req.size16;
  assign rr_wr  = req.wr && hit && ofs == `WWD_OFS_RR;
  assign key    = lane(req.size16, req.wdata);

  // power-mode transitions
  assign wake    = normal_mode && !normal_d_r;
  assign restart = wake || fire;

  // timeout in effect
  always_comb
  begin
    if (state_r == wwd_pkg::WWD_ST_INIT)
      limit = to_ticks(`WWD_RST_TO);
    else
      limit = to_ticks(timeout_select_r);
  end

  // window open in the second half of the timeout, and throughout the initial period
  always_comb
  begin
    case (state_r)
      wwd_pkg::WWD_ST_INIT:   win_open = 1'b1;
      wwd_pkg::WWD_ST_WINDOW: win_open = cnt_r >= (limit >> 1);
      default:                win_open = 1'b0;
    endcase
  end

  // disabled flag, forced in low power
  assign dis_flag = !normal_mode || state_r == wwd_pkg::WWD_ST_OFF;

  // control register next value
  always_comb
  begin
    timeout_select_nxt = timeout_select_r;
    test_bit_nxt       = test_bit_r;
    locked_nxt         = locked_r;
    if (ctl_wr && normal_mode)
    begin
      // per-bit masked update of the selector
      for (int i = 0; i < 3; i++)
      begin
        if (req.wdata[`WWD_CTL_TOM_LSB + i])
          timeout_select_nxt[i] = req.wdata[`WWD_CTL_TO_LSB + i];
      end
      // 000 ignored once locked
      if (timeout_select_nxt == `WWD_TO_OFF && locked_r)
        timeout_select_nxt = timeout_select_r;
      else if (timeout_select_nxt != `WWD_TO_OFF)
        locked_nxt = 1'b1;
      // test bit stored only, steers nothing
      if (req.wdata[`WWD_CTL_TSTM_BIT])
        test_bit_nxt = req.wdata[`WWD_CTL_TST_BIT];
    end
    // accepted rearm with default kept also locks
    if (state_nxt == wwd_pkg::WWD_ST_WINDOW && rr_wr)
      locked_nxt = 1'b1;
  end

  // state, counter and fault detection
  always_comb
  begin
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    key_b_next_nxt = key_b_next_r;
    fire           = 1'b0;
    case (state_r)
      // disabled: count nothing, ignore rearm
      wwd_pkg::WWD_ST_OFF:
      begin
        cnt_nxt = '0;
        if (timeout_select_nxt != `WWD_TO_OFF)
        begin
          // later enable restarts in initial mode
          state_nxt      = wwd_pkg::WWD_ST_INIT;
          key_b_next_nxt = 1'b0;
        end
      end
      // fixed initial period, first key 0xaa
      wwd_pkg::WWD_ST_INIT:
      begin
        if (rr_wr)
        begin
          if (key == `WWD_KEY_A)
          begin
            state_nxt      = wwd_pkg::WWD_ST_WINDOW;
            cnt_nxt        = '0;
            key_b_next_nxt = 1'b1;
          end
          else
            fire = 1'b1;
        end
        else if (tick)
        begin
          if (cnt_r >= limit - CNT_W'(1))
            fire = 1'b1;
          else
            cnt_nxt = cnt_r + CNT_W'(1);
        end
        if (timeout_select_nxt == `WWD_TO_OFF)
        begin
          state_nxt = wwd_pkg::WWD_ST_OFF;
          fire      = 1'b0;
        end
      end
      // closed then open window
      wwd_pkg::WWD_ST_WINDOW:
      begin
        if (rr_wr)
        begin
          if (!win_open)
            fire = 1'b1;
          else if (key == (key_b_next_r ? `WWD_KEY_B : `WWD_KEY_A))
          begin
            cnt_nxt        = '0;
            key_b_next_nxt = !key_b_next_r;
          end
          else
            fire = 1'b1;
        end
        else if (tick)
        begin
          if (cnt_r >= limit - CNT_W'(1))
            fire = 1'b1;
          else
            cnt_nxt = cnt_r + CNT_W'(1);
        end
        if (timeout_select_nxt == `WWD_TO_OFF)
        begin
          state_nxt = wwd_pkg::WWD_ST_OFF;
          fire      = 1'b0;
        end
      end
      // low power: counter held at zero, state kept until wake
      wwd_pkg::WWD_ST_SLEEP:
      begin
        cnt_nxt = '0;
      end
      default:
      begin
        state_nxt = wwd_pkg::WWD_ST_INIT;
        cnt_nxt   = '0;
      end
    endcase
    // leaving Normal mode overrides everything
    if (!normal_mode)
    begin
      state_nxt = wwd_pkg::WWD_ST_SLEEP;
      fire      = 1'b0;
    end
  end

  // state register, power-on values on restart
  always_ff @(posedge clk)
  begin
    if (!resetn || restart)
    begin
      state_r      <= wwd_pkg::WWD_ST_INIT;
      cnt_r        <= '0;
      key_b_next_r <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      key_b_next_r <= key_b_next_nxt;
    end
  end

  // control register and lock
  always_ff @(posedge clk)
  begin
    if (!resetn || restart)
    begin
      timeout_select_r <= `WWD_RST_TO;
      test_bit_r       <= `WWD_RST_TST;
      locked_r         <= 1'b0;
    end
    else
    begin
      timeout_select_r <= timeout_select_nxt;
      test_bit_r       <= test_bit_nxt;
      locked_r         <= locked_nxt;
    end
  end

  // last rearm byte taken in Normal mode while not disabled, readable back
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rearm_val_r <= 8'h00;
    else if (rr_wr && normal_mode && state_r != wwd_pkg::WWD_ST_OFF)
      rearm_val_r <= key;
  end

  // power-mode edge tracking
  always_ff @(posedge clk)
  begin
    if (!resetn)
      normal_d_r <= 1'b1;
    else
      normal_d_r <= normal_mode;
  end

  // reset request pulse, one cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
      wd_reset_req <= 1'b0;
    else
      wd_reset_req <= fire;
  end

  // status byte
  always_comb
  begin
    status                  = 8'h00;
    status[`WWD_SR_OFF_BIT] = dis_flag;
    status[`WWD_SR_WO_BIT]  = win_open;
  end

  // read answer, registered, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rsp.valid <= 1'b0;
      rsp.data  <= 16'h0000;
    end
    else
    begin
      rsp.valid <= req.rd;
      rsp.data  <= 16'h0000;
      if (req.rd && hit)
      begin
        case (ofs)
          // mask bits read zero
          `WWD_OFS_CTL:
            rsp.data <= {8'h00, test_bit_r, 4'h0, timeout_select_r};
          // status, then reserved byte
          `WWD_OFS_SR:
            rsp.data <= req.size16 ? {status, 8'h00} : {8'h00, status};
          // rearm byte, then reserved byte
          `WWD_OFS_RR:
            rsp.data <= req.size16 ? {rearm_val_r, 8'h00}
                                   : {8'h00, rearm_val_r};
          // reserved and unmapped read zero
          default:
            rsp.data <= 16'h0000;
        endcase
      end
    end
  end

endmodule : wwd_top

/* File: rtl/wwd_regs.svh */
// register offsets, field positions, reset values, keys and timeouts
// assumes inclusion by bare name from the watchdog design files
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

// two windows of the global address space
`define WWD_BASE_BLK      16'h0200
`define WWD_BASE_NBLK     16'h0300
`define WWD_BASE_MASK     16'hff00

// register offsets inside a window
`define WWD_OFS_CTL       8'h10
`define WWD_OFS_SR        8'h12
`define WWD_OFS_RSV_A     8'h13
`define WWD_OFS_RR        8'h14
`define WWD_OFS_RSV_B     8'h15
`define WWD_OFS_RSV_C     8'h16
`define WWD_OFS_RSV_D     8'h17

// control field positions
`define WWD_CTL_TST_BIT   7
`define WWD_CTL_TSTM_BIT  15
`define WWD_CTL_TO_LSB    0
`define WWD_CTL_TOM_LSB   8

// status field positions
`define WWD_SR_WO_BIT     0
`define WWD_SR_OFF_BIT    1

// reset values and the off selector
`define WWD_RST_TO        3'h4
`define WWD_RST_TST       1'h1
`define WWD_TO_OFF        3'h0

// rearm keys
`define WWD_KEY_A         8'haa
`define WWD_KEY_B         8'h55

// timeouts in ms, by selector 1..7, and the fixed initial one
`define WWD_TO1_MS        4
`define WWD_TO2_MS        16
`define WWD_TO3_MS        64
`define WWD_TO4_MS        256
`define WWD_TO5_MS        512
`define WWD_TO6_MS        1024
`define WWD_TO7_MS        2048
`define WWD_INIT_TO_MS    256

`endif

/* File: rtl/wwd_pkg.sv */
// types shared by the window watchdog design files
// assumes nothing beyond a SystemVerilog compiler
package wwd_pkg;

  // watchdog operating states
  typedef enum logic [2:0]
  {
    WWD_ST_OFF,
    WWD_ST_INIT,
    WWD_ST_WINDOW,
    WWD_ST_SLEEP
  } wwd_state_t;

  // one register access from the die interface
  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic        size16;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wwd_req_t;

  // read answer
  typedef struct packed
  {
    logic        valid;
    logic [15:0] data;
  } wwd_rsp_t;

endpackage : wwd_pkg

/* File: rtl/wwd_lp_tick.sv */
// low-power oscillator edge detector giving one-cycle ticks on clk
// assumes the oscillator is far slower than clk (under half its rate)
module wwd_lp_tick
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // oscillator pin, asynchronous to clk
  input  wire logic lp_osc_in,
  // one pulse per oscillator rising edge
  output logic      tick
);

  logic sync1_r;  // first synchroniser stage
  logic sync2_r;  // second synchroniser stage
  logic prev_r;   // delayed copy for edge detect

  // two-stage synchroniser, then delay for edge detect
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      // all stages start high: a pin already high at release is no edge
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r  <= 1'b1;
    end
    else
    begin
      sync1_r <= lp_osc_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // rising edge of the synchronised oscillator
  assign tick = sync2_r & ~prev_r;

endmodule : wwd_lp_tick

/* File: dv/wwd_sw_model.sv */
// mcu software model: makes register accesses on the watchdog bus
// assumes clk shared with the design; tb calls acc hierarchically
module wwd_sw_model
(
  // clock
  input  wire logic              clk,
  // register access
  output wwd_pkg::wwd_req_t      req,
  input  wire wwd_pkg::wwd_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial req = '0;

  // one strobe cycle, dropped at the edge that takes it; answer taken
  // at the next edge, where it is sampled; then let counters settle
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    req <= '{wr: w, rd: !w, size16: (a[7:0] == 8'h10), addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    q = rsp.data;
    #1;
  endtask : acc
endmodule : wwd_sw_model

/* File: dv/wwd_top_props.sv */
// checker of the watchdog ports, bound into wwd_top
// assumes one clock and synchronous active-low reset
module wwd_top_props
#(
  parameter int LP_TICKS_PER_MS = 16,
  parameter int CNT_W           = 20
)
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              low_power_osc_clock,
  input wire logic              normal_mode,
  input wire wwd_pkg::wwd_req_t req,
  input wire wwd_pkg::wwd_rsp_t rsp,
  input wire logic              wd_reset_req
);
  logic       hit;     // address in one of the two windows
  logic [7:0] ofs;     // offset inside the window
  logic       fresh_r; // no control or rearm write since reset

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  assign hit = req.addr[15:8] inside {8'h02, 8'h03};
  assign ofs = req.addr[7:0];

  // first rearm after reset must be the 0xaa key
  always_ff @(posedge clk)
    if (!resetn)
      fresh_r <= 1'b1;
    else if (req.wr && hit && (ofs == 8'h10 || ofs == 8'h14))
      fresh_r <= 1'b0;

  a_read_answer: assert property (req.rd |=> rsp.valid)
    else $error("no answer after read");
  a_no_stray: assert property (!req.rd |=> !rsp.valid && rsp.data == 16'h0)
    else $error("answer without read");
  a_reserved_zero: assert property (req.rd && hit && ofs inside {8'h13, 8'h15, 8'h16, 8'h17}
    |=> rsp.data == 16'h0) else $error("reserved read not zero");
  a_ctl_layout: assert property (req.rd && hit && ofs == 8'h10
    |=> rsp.data[15:8] == 8'h0 && rsp.data[6:3] == 4'h0) else $error("control read layout");
  a_status_layout: assert property (req.rd && hit && ofs == 8'h12 && !req.size16
    |=> rsp.data[7:2] == 6'h0) else $error("status read layout");
  a_stop_off_flag: assert property (req.rd && hit && ofs == 8'h12 && !req.size16
    && !normal_mode |=> rsp.data[1]) else $error("off flag clear in stop");
  a_reset_pulse: assert property (wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");
  a_quiet_stop: assert property (!normal_mode ##1 !normal_mode |-> !wd_reset_req)
    else $error("reset request in stop");
  a_first_key: assert property (fresh_r && normal_mode && $past(normal_mode) && req.wr && hit
    && ofs == 8'h14 && !req.size16 && req.wdata[7:0] != 8'haa |=> wd_reset_req)
    else $error("wrong first key not punished");
endmodule : wwd_top_props

bind wwd_top wwd_top_props #(.LP_TICKS_PER_MS(LP_TICKS_PER_MS), .CNT_W(CNT_W)) props
  (.clk(clk), .resetn(resetn), .low_power_osc_clock(low_power_osc_clock),
   .normal_mode(normal_mode), .req(req), .rsp(rsp), .wd_reset_req(wd_reset_req));

/* File: dv/tb.sv */
// self-checking bench of the window watchdog
// assumes one oscillator tick per ms so timeouts count in ticks
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, resetn, osc, normal_mode, wd_reset_req;
  wwd_pkg::wwd_req_t req;
  wwd_pkg::wwd_rsp_t rsp;
  logic [15:0]       fires, q;   // reset requests seen, last read
  logic [2:0]        div;        // oscillator divider
  logic [31:0]       seed;       // xorshift state
  logic [7:0]        k;          // random key
  int                fails, checks_done;

  wwd_top #(.LP_TICKS_PER_MS(1), .CNT_W(20)) uut (.clk(clk), .resetn(resetn),
    .low_power_osc_clock(osc), .normal_mode(normal_mode), .req(req), .rsp(rsp),
    .wd_reset_req(wd_reset_req));
  wwd_sw_model m (.clk(clk), .req(req), .rsp(rsp));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // oscillator at an eighth of clk, count reset requests
  always @(posedge clk)
  begin
    div <= div + 3'h1;
    osc <= div[2];
    if (wd_reset_req === 1'b1)
      fires = fires + 16'h1;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // expected control and status words
  function automatic logic [15:0] ce(input logic t, input logic [2:0] s);
    return {8'h0, t, 4'h0, s};
  endfunction : ce
  function automatic logic [15:0] se(input logic o, input logic w);
    return {14'h0, o, w};
  endfunction : se

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    m.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    m.acc(1'b0, a, 16'h0, q);
  endtask : rd
  task automatic rc(input string n, input logic [15:0] a, input logic [15:0] e);
    rd(a);
    chk(n, q, e);
  endtask : rc
  task automatic ticks(input int n);
    repeat (n) @(posedge osc);
  endtask : ticks

  // reset low for two sampling edges, then clear the request count
  task automatic rst;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 fires = 16'h0;
  endtask : rst

  task automatic stop_test;
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // cut a hang short
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test;
  end

  initial
  begin
    resetn = 1'b0; normal_mode = 1'b1; osc = 1'b0; div = 3'h0; fires = 16'h0;
    seed = 32'h00014f5f; fails = 0; checks_done = 0;
    rst;
    rc("ctl", 16'h0210, ce(1'b1, 3'h4));
    rc("sr", 16'h0212, se(1'b0, 1'b1));
    // initial period runs out
    ticks(250);
    chk("early", fires, 16'h0);
    ticks(12);
    chk("init_to", fires, 16'h1);
    rc("restart", 16'h0312, se(1'b0, 1'b1));
    // random wrong first keys
    repeat (4)
    begin
      rst;
      seed = xs(seed);
      k = (seed[7:0] == 8'haa) ? 8'h55 : seed[7:0];
      wr(16'h0214, {8'h0, k});
      chk("key", fires, 16'h1);
    end
    // rearm inside closed window
    rst;
    wr(16'h0214, 16'h00aa);
    wr(16'h0210, 16'h0702);
    rc("ctl2", 16'h0210, ce(1'b1, 3'h2));
    rc("closed", 16'h0212, se(1'b0, 1'b0));
    wr(16'h0214, 16'h0055);
    chk("closed_rr", fires, 16'h1);
    // alternating keys in open window, then a repeated key
    rst;
    wr(16'h0214, 16'h00aa);
    wr(16'h0210, 16'h0702);
    ticks(11);
    rc("open", 16'h0212, se(1'b0, 1'b1));
    wr(16'h0214, 16'h0055);
    rc("reclosed", 16'h0212, se(1'b0, 1'b0));
    ticks(11);
    wr(16'h0214, 16'h00aa);
    chk("alt", fires, 16'h0);
    ticks(11);
    wr(16'h0214, 16'h00aa);
    chk("same_key", fires, 16'h1);
    // rearm locks default, then window timeout
    rst;
    wr(16'h0214, 16'h00aa);
    wr(16'h0210, 16'h0700);
    rc("lock_rr", 16'h0210, ce(1'b1, 3'h4));
    wr(16'h0210, 16'h0702);
    ticks(13);
    chk("win_early", fires, 16'h0);
    ticks(6);
    chk("win_to", fires, 16'h1);
    // disabled by first write, rearm ignored, enabled later
    rst;
    wr(16'h0210, 16'h0700);
    rd(16'h0212);
    chk("off", 16'(q[1]), 16'h1);
    wr(16'h0214, 16'h0055);
    ticks(300);
    chk("off_rr", fires, 16'h0);
    wr(16'h0210, 16'h0702);
    rd(16'h0212);
    chk("on", 16'(q[1]), 16'h0);
    wr(16'h0214, 16'h00aa);
    wr(16'h0210, 16'h0700);
    rc("lock", 16'h0210, ce(1'b1, 3'h2));
    wr(16'h0210, 16'h0005);
    rc("mask", 16'h0210, ce(1'b1, 3'h2));
    wr(16'h0210, 16'h8003);
    rc("tst", 16'h0210, ce(1'b0, 3'h2));
    // stop mode, then wake
    rst;
    @(posedge clk) normal_mode <= 1'b0;
    rd(16'h0212);
    chk("stop", 16'(q[1]), 16'h1);
    wr(16'h0214, 16'h0013);
    ticks(300);
    chk("stop_q", fires, 16'h0);
    @(posedge clk) normal_mode <= 1'b1;
    rc("wake", 16'h0212, se(1'b0, 1'b1));
    rc("wake_c", 16'h0210, ce(1'b1, 3'h4));
    // random reserved places in both windows
    repeat (6)
    begin
      seed = xs(seed);
      k = (seed[1:0] == 2'h0) ? 8'h13 : 8'h14 + {6'h0, seed[1:0]};
      rc("rsv", {(seed[8] ? 8'h03 : 8'h02), k}, 16'h0);
    end
    rc("unmapped", 16'h0412, 16'h0);
    stop_test;
  end
endmodule : tb
